// file: inc/phc_defines.svh
// Offsets, field positions, reset values and timing counts for the
// host-side configuration and control register block.
// Assumes a 25 MHz transaction clock and dword-aligned byte offsets.
`ifndef PHC_DEFINES_SVH
`define PHC_DEFINES_SVH

// Configuration header dword offsets (byte addresses)
`define PHC_CFG_ID        8'h00
`define PHC_CFG_CMDSTAT   8'h04
`define PHC_CFG_CLASSREV  8'h08
`define PHC_CFG_MISC      8'h0C
`define PHC_CFG_BAR0      8'h10
`define PHC_CFG_BAR1      8'h14
`define PHC_CFG_BAR2      8'h18
`define PHC_CFG_BAR3      8'h1C
`define PHC_CFG_BAR4      8'h20
`define PHC_CFG_ROMBAR    8'h30
`define PHC_CFG_INTR      8'h3C
// Size of the predefined header in bytes
`define PHC_CFG_HDR_BYTES 8'h40

// Control region offsets inside one 64K copy
`define PHC_R0_SOFT_RESET 16'h0000
`define PHC_R0_INT_EN     16'h0008
`define PHC_R0_INT_FLAGS  16'h0010
`define PHC_R0_IN_SPACE   16'h0018
`define PHC_R0_OUT_WORDS  16'h0020
// Address bit that selects the byte-swapped copy
`define PHC_R0_SWAP_BIT   16
// Control region size as a power of two (128K)
`define PHC_R0_SIZE_LOG2  17
// Expansion ROM size as a power of two (64K x 8)
`define PHC_ROM_SIZE_LOG2 16

// Field values
`define PHC_CLASS_DISPLAY 24'h038000
`define PHC_CLASS_COMPAT  24'h000000
`define PHC_HEADER_SINGLE 8'h00
`define PHC_CMD_MEM_BIT   1
`define PHC_CMD_WMASK     16'h0006
`define PHC_STAT_W1C_MASK 16'hF900
`define PHC_SOFT_BUSY_BIT 31
`define PHC_INT_SOURCES   5
`define PHC_IN_SPACE_CAP  6'h10
`define PHC_IN_FIFO_DEPTH 6'h20

// Timing: soft reset length and ROM access time
`define PHC_CLK_NS        40
`define PHC_ROM_ACCESS_NS 150
`define PHC_ROM_CYCLES    ((`PHC_ROM_ACCESS_NS + `PHC_CLK_NS - 1) / `PHC_CLK_NS)
`define PHC_SOFT_RST_CYC  16

`endif

// file: inc/phc_pkg.sv
// Types for the host-side configuration and control register block.
// Assumes the includer uses package-scoped names only.
package phc_pkg;

	// Transaction kinds seen by the target
	typedef enum logic [1:0] {
		CMD_CFG_RD,
		CMD_CFG_WR,
		CMD_MEM_RD,
		CMD_MEM_WR
	} phc_cmd_e;

	// One decoded bus transaction
	typedef struct packed {
		logic        valid;
		phc_cmd_e    cmd;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} phc_req_s;

	// Answer to a transaction
	typedef struct packed {
		logic        done;
		logic        claimed;
		logic [31:0] rdata;
	} phc_rsp_s;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ROM,
		ST_ANSWER
	} phc_state_e;

endpackage : phc_pkg

// file: logic/phc_regs.sv
// Configuration header, expansion ROM port and first control registers.
// Assumes transactions arrive decoded on i_req, one at a time, and that
// the caller waits for o_rsp.done before issuing the next one.
// How it works
// - Header reached only by config transactions
// - 64-byte header; other config bytes read zero
// - Revision register returns fixed code
// - Class display-other, or zero when strapped
// - Header type says single function
// - Command zero blocks all memory cycles
// - Status reads plain, writes clear ones
// - Latency timer holds burst clock limit
// - Max latency loaded from strap pins
// - Control base is 32-bit non-prefetch memory
// - Second apertures mirror first aperture sizes
// - 64K ROM, reads only, writes ignored
// - ROM address out, data in, strobe low
// - 128K control region, upper copy swapped
// - Reset register write resets core only
// - Soft reset busy flag readable
// - Five interrupt enables, clear at reset
// - Source interrupts only when enabled
// - Flags per source, write one clears
// - Input space capped at sixteen
// - Input space readable any time
// - Output words report zero to eight
`timescale 1ns/1ps
`include "phc_defines.svh"

module phc_regs #(
	parameter int           LOCAL_SIZE_LOG2 = 24,    // Localbuffer aperture
	parameter int           FRAME_SIZE_LOG2 = 25,    // Framebuffer aperture
	parameter logic [15:0]  MAKER_CODE      = 16'hA5C3, // Arbitrary value
	parameter logic [15:0]  PART_CODE       = 16'h7E21, // Arbitrary value
	parameter logic [7:0]   REVISION        = 8'h5A,    // Arbitrary value
	parameter logic [7:0]   INT_PIN         = 8'h01,
	parameter int           SOFT_RST_CYC    = `PHC_SOFT_RST_CYC
) (
	input  wire logic               i_clock,
	input  wire logic               i_rst_n,
	input  wire logic               i_clk_en,
	input  wire phc_pkg::phc_req_s  i_req,
	output phc_pkg::phc_rsp_s       o_rsp,
	input  wire logic               i_base_class_zero,
	input  wire logic [1:0]         i_max_lat_strap,
	input  wire logic [4:0]         i_int_events,
	input  wire logic [4:0]         i_status_events,
	input  wire logic [5:0]         i_in_fifo_used,
	input  wire logic [3:0]         i_out_fifo_words,
	output logic [15:0]             o_rom_addr,
	output logic                    o_rom_addr_oe,
	input  wire logic [7:0]         i_rom_rdata,
	output logic                    o_rom_read_strobe_n,
	output logic                    o_core_soft_reset,
	output logic                    o_inta_n
);

	localparam int ROM_CYC = (`PHC_ROM_CYCLES < 3) ? 3 : `PHC_ROM_CYCLES;

	// Byte-enable merge of write data into a stored word
	function automatic logic [31:0] merge_be(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge_be

	// Byte reversal for the big-endian copy of the control space
	function automatic logic [31:0] swap32(input logic [31:0] v);
		return {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction : swap32

	// Address mask that keeps the base bits of a region
	function automatic logic [31:0] size_mask(input int log2);
		return ~((32'h1 << log2) - 32'h1);
	endfunction : size_mask

	// Strap synchronisers: three stages, change once two and three agree
	logic [2:0] strap_s1_reg, strap_s2_reg, strap_s3_reg;
	logic [2:0] strap_ok_reg;                 // Agreed strap level
	logic [2:0] strap_ok_now;                 // Agreed level at this edge
	logic [7:0] rom_s1_reg, rom_s2_reg, rom_s3_reg;  // ROM data pins
	logic [7:0] rom_ok_reg;                   // Agreed ROM data level

	// Reset capture must see the level that agrees at this very edge
	assign strap_ok_now = (strap_s2_reg == strap_s3_reg) ? strap_s3_reg :
		strap_ok_reg;

	// Synchroniser chain, no reset needed on data flops
	always_ff @(posedge i_clock) begin
		if (i_clk_en) begin
			strap_s1_reg <= {i_base_class_zero, i_max_lat_strap};
			strap_s2_reg <= strap_s1_reg;
			strap_s3_reg <= strap_s2_reg;
			rom_s1_reg   <= i_rom_rdata;
			rom_s2_reg   <= rom_s1_reg;
			rom_s3_reg   <= rom_s2_reg;
			if (strap_s2_reg == strap_s3_reg) begin
				strap_ok_reg <= strap_s3_reg;
			end
			// ROM byte counts once stages two and three agree
			if (rom_s2_reg == rom_s3_reg) begin
				rom_ok_reg <= rom_s3_reg;
			end
		end
	end

	// Register state
	logic [2:0]  command_reg, command_next;    // IO, memory, master
	logic [4:0]  status_reg, status_next;      // Sticky bits 15,14,13,12,11
	logic [7:0]  lat_timer_reg, lat_timer_next;
	logic [7:0]  int_line_reg, int_line_next;
	logic [1:0]  max_lat_reg, max_lat_next;    // Strap code, value = code<<6
	logic        class_zero_reg, class_zero_next;
	logic [31:0] bar_reg [5], bar_next [5];    // Control, A local/frame, B
	logic [31:0] rom_bar_reg, rom_bar_next;
	logic [4:0]  int_en_reg, int_en_next;
	logic [4:0]  int_flag_reg, int_flag_next;
	logic [15:0] soft_cnt_reg, soft_cnt_next;  // Soft reset cycles left
	phc_pkg::phc_state_e state_reg, state_next;
	logic [3:0]  rom_cnt_reg, rom_cnt_next;
	phc_pkg::phc_rsp_s rsp_reg, rsp_next;
	logic [15:0] rom_addr_reg, rom_addr_next;
	logic        rom_oe_reg, rom_oe_next;
	logic        rom_stb_n_reg, rom_stb_n_next;
	logic        core_rst_reg, core_rst_next;
	logic        inta_n_reg, inta_n_next;

	// Size masks per base register
	logic [31:0] bar_mask [5];
	assign bar_mask[0] = size_mask(`PHC_R0_SIZE_LOG2);
	assign bar_mask[1] = size_mask(LOCAL_SIZE_LOG2);
	assign bar_mask[2] = size_mask(FRAME_SIZE_LOG2);
	assign bar_mask[3] = bar_mask[1];
	assign bar_mask[4] = bar_mask[2];

	// Memory decode, gated by the memory space enable
	logic [4:0] bar_hit;
	logic       rom_hit;
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_hit
			assign bar_hit[g] = command_reg[`PHC_CMD_MEM_BIT] &&
				((i_req.addr & bar_mask[g]) == (bar_reg[g] & bar_mask[g]));
		end
	endgenerate
	assign rom_hit = command_reg[`PHC_CMD_MEM_BIT] && rom_bar_reg[0] &&
		((i_req.addr & size_mask(`PHC_ROM_SIZE_LOG2)) ==
		 (rom_bar_reg & size_mask(`PHC_ROM_SIZE_LOG2)));

	// Derived read-only values
	logic [23:0] class_code;
	logic [5:0]  in_free_raw;
	logic [31:0] in_space;
	logic        take;
	assign class_code = class_zero_reg ? `PHC_CLASS_COMPAT : `PHC_CLASS_DISPLAY;
	assign in_free_raw = `PHC_IN_FIFO_DEPTH - i_in_fifo_used;
	assign in_space = {26'h0, (in_free_raw > `PHC_IN_SPACE_CAP) ?
		`PHC_IN_SPACE_CAP : in_free_raw};
	assign take = i_req.valid && (state_reg == phc_pkg::ST_IDLE);

	// Configuration read mux
	logic [31:0] cfg_rdata;
	always_comb begin
		cfg_rdata = 32'h0;
		case (i_req.addr[7:0] & 8'hFC)
			`PHC_CFG_ID:       cfg_rdata = {PART_CODE, MAKER_CODE};
			`PHC_CFG_CMDSTAT:  cfg_rdata = {status_reg, 11'h0, 13'h0,
				command_reg};
			`PHC_CFG_CLASSREV: cfg_rdata = {class_code, REVISION};
			`PHC_CFG_MISC:     cfg_rdata = {8'h0, `PHC_HEADER_SINGLE,
				lat_timer_reg, 8'h0};
			`PHC_CFG_BAR0:     cfg_rdata = bar_reg[0] & bar_mask[0];
			`PHC_CFG_BAR1:     cfg_rdata = bar_reg[1] & bar_mask[1];
			`PHC_CFG_BAR2:     cfg_rdata = bar_reg[2] & bar_mask[2];
			`PHC_CFG_BAR3:     cfg_rdata = bar_reg[3] & bar_mask[3];
			`PHC_CFG_BAR4:     cfg_rdata = bar_reg[4] & bar_mask[4];
			`PHC_CFG_ROMBAR:   cfg_rdata = rom_bar_reg;
			`PHC_CFG_INTR:     cfg_rdata = {max_lat_reg, 6'h0, 8'h0, INT_PIN,
				int_line_reg};
			default:           cfg_rdata = 32'h0;
		endcase
	end

	// Control region read mux (little-endian view)
	logic [31:0] r0_rdata;
	always_comb begin
		r0_rdata = 32'h0;
		case (i_req.addr[15:0])
			`PHC_R0_SOFT_RESET: r0_rdata = {(soft_cnt_reg != 16'h0), 31'h0};
			`PHC_R0_INT_EN:     r0_rdata = {27'h0, int_en_reg};
			`PHC_R0_INT_FLAGS:  r0_rdata = {27'h0, int_flag_reg};
			`PHC_R0_IN_SPACE:   r0_rdata = in_space;
			`PHC_R0_OUT_WORDS:  r0_rdata = {28'h0, i_out_fifo_words};
			default:            r0_rdata = 32'h0;
		endcase
	end

	// Next-state logic for all register state
	logic [31:0] wr_word;    // Control write data in little-endian order
	logic [4:0]  flag_clr;
	logic [4:0]  stat_clr;
	always_comb begin
		command_next    = command_reg;
		status_next     = status_reg;
		lat_timer_next  = lat_timer_reg;
		int_line_next   = int_line_reg;
		max_lat_next    = max_lat_reg;
		class_zero_next = class_zero_reg;
		bar_next        = bar_reg;
		rom_bar_next    = rom_bar_reg;
		int_en_next     = int_en_reg;
		soft_cnt_next   = soft_cnt_reg;
		state_next      = state_reg;
		rom_cnt_next    = rom_cnt_reg;
		rsp_next        = '0;
		rom_addr_next   = rom_addr_reg;
		rom_oe_next     = rom_oe_reg;
		rom_stb_n_next  = rom_stb_n_reg;
		flag_clr        = 5'h0;
		stat_clr        = 5'h0;
		wr_word = i_req.addr[`PHC_R0_SWAP_BIT] ? swap32(i_req.wdata) :
			i_req.wdata;
		// Soft reset countdown
		if (soft_cnt_reg != 16'h0) begin
			soft_cnt_next = soft_cnt_reg - 16'h1;
		end
		case (state_reg)
			phc_pkg::ST_IDLE: begin
				if (take) begin
					rsp_next.done = 1'b1;
					case (i_req.cmd)
						phc_pkg::CMD_CFG_RD: begin
							rsp_next.claimed = 1'b1;
							rsp_next.rdata   = cfg_rdata;
						end
						phc_pkg::CMD_CFG_WR: begin
							rsp_next.claimed = 1'b1;
							case (i_req.addr[7:0] & 8'hFC)
								`PHC_CFG_CMDSTAT: begin
									command_next = 3'(merge_be(
										{29'h0, command_reg}, i_req.wdata, i_req.be))
										& 3'(`PHC_CMD_WMASK);
									if (i_req.be[3]) begin
										stat_clr = i_req.wdata[31:27];
									end
								end
								`PHC_CFG_MISC: if (i_req.be[1]) begin
									lat_timer_next = i_req.wdata[15:8];
								end
								`PHC_CFG_ROMBAR: begin
									rom_bar_next = merge_be(rom_bar_reg, i_req.wdata,
										i_req.be) & (size_mask(`PHC_ROM_SIZE_LOG2)
										| 32'h1);
								end
								`PHC_CFG_INTR: if (i_req.be[0]) begin
									int_line_next = i_req.wdata[7:0];
								end
								default: begin
									for (int k = 0; k < 5; k++) begin
										if ((i_req.addr[7:0] & 8'hFC) ==
												`PHC_CFG_BAR0 + 8'(4 * k)) begin
											bar_next[k] = merge_be(bar_reg[k],
												i_req.wdata, i_req.be) & bar_mask[k];
										end
									end
								end
							endcase
						end
						phc_pkg::CMD_MEM_RD: begin
							if (bar_hit[0]) begin
								rsp_next.claimed = 1'b1;
								rsp_next.rdata = i_req.addr[`PHC_R0_SWAP_BIT] ?
									swap32(r0_rdata) : r0_rdata;
							end else if (rom_hit) begin
								rsp_next.done  = 1'b0;
								state_next     = phc_pkg::ST_ROM;
								rom_cnt_next   = 4'(ROM_CYC);
								rom_addr_next  = i_req.addr[15:0];
								rom_oe_next    = 1'b1;
								rom_stb_n_next = 1'b0;
							end else begin
								rsp_next.claimed = |bar_hit[4:1];
							end
						end
						phc_pkg::CMD_MEM_WR: begin
							rsp_next.claimed = |bar_hit;
							if (bar_hit[0]) begin
								case (i_req.addr[15:0])
									`PHC_R0_SOFT_RESET:
										soft_cnt_next = 16'(SOFT_RST_CYC);
									`PHC_R0_INT_EN:
										int_en_next = 5'(merge_be(
											{27'h0, int_en_reg}, wr_word, i_req.be));
									`PHC_R0_INT_FLAGS: if (i_req.be[0]) begin
										flag_clr = wr_word[4:0];
									end
									default: ;
								endcase
							end
						end
						default: ;
					endcase
				end
			end
			phc_pkg::ST_ROM: begin
				rom_cnt_next = rom_cnt_reg - 4'h1;
				if (rom_cnt_reg == 4'h1) begin
					state_next = phc_pkg::ST_ANSWER;
				end
			end
			phc_pkg::ST_ANSWER: begin
				rsp_next.done    = 1'b1;
				rsp_next.claimed = 1'b1;
				rsp_next.rdata   = {4{rom_ok_reg}};
				rom_oe_next      = 1'b0;
				rom_stb_n_next   = 1'b1;
				state_next       = phc_pkg::ST_IDLE;
			end
			default: state_next = phc_pkg::ST_IDLE;
		endcase
		status_next = (status_reg & ~stat_clr) | i_status_events;
		int_flag_next = (int_flag_reg & ~flag_clr) | i_int_events;
		core_rst_next = (soft_cnt_next != 16'h0);
		inta_n_next = ~|(int_flag_next & int_en_next);
	end

	// Register update; straps caught while reset is held
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			command_reg    <= 3'h0;
			status_reg     <= 5'h0;
			lat_timer_reg  <= 8'h0;
			int_line_reg   <= 8'h0;
			max_lat_reg    <= strap_ok_now[1:0];
			class_zero_reg <= strap_ok_now[2];
			for (int k = 0; k < 5; k++) begin
				bar_reg[k] <= 32'h0;
			end
			rom_bar_reg    <= 32'h0;
			int_en_reg     <= 5'h0;
			int_flag_reg   <= 5'h0;
			soft_cnt_reg   <= 16'h0;
			state_reg      <= phc_pkg::ST_IDLE;
			rom_cnt_reg    <= 4'h0;
			rsp_reg        <= '0;
			rom_addr_reg   <= 16'h0;
			rom_oe_reg     <= 1'b0;
			rom_stb_n_reg  <= 1'b1;
			core_rst_reg   <= 1'b0;
			inta_n_reg     <= 1'b1;
		end else if (i_clk_en) begin
			command_reg    <= command_next;
			status_reg     <= status_next;
			lat_timer_reg  <= lat_timer_next;
			int_line_reg   <= int_line_next;
			max_lat_reg    <= max_lat_next;
			class_zero_reg <= class_zero_next;
			bar_reg        <= bar_next;
			rom_bar_reg    <= rom_bar_next;
			int_en_reg     <= int_en_next;
			int_flag_reg   <= int_flag_next;
			soft_cnt_reg   <= soft_cnt_next;
			state_reg      <= state_next;
			rom_cnt_reg    <= rom_cnt_next;
			rsp_reg        <= rsp_next;
			rom_addr_reg   <= rom_addr_next;
			rom_oe_reg     <= rom_oe_next;
			rom_stb_n_reg  <= rom_stb_n_next;
			core_rst_reg   <= core_rst_next;
			inta_n_reg     <= inta_n_next;
		end
	end

	// Outputs straight from flops
	assign o_rsp               = rsp_reg;
	assign o_rom_addr          = rom_addr_reg;
	assign o_rom_addr_oe       = rom_oe_reg;
	assign o_rom_read_strobe_n = rom_stb_n_reg;
	assign o_core_soft_reset   = core_rst_reg;
	assign o_inta_n            = inta_n_reg;

	// Checks, sampled only while the clock enable is high
	default clocking cb @(posedge i_clock iff i_clk_en); endclocking
	default disable iff (!i_rst_n);

	chk_int_line_level: assert property (
		inta_n_reg == ~|(int_flag_reg & int_en_reg))
		else $error("interrupt line disagrees with flags and enables");
	chk_flag_set_wins: assert property (
		|i_int_events |=> ((int_flag_reg & $past(i_int_events)) ==
			$past(i_int_events)))
		else $error("interrupt event lost");
	chk_in_space_cap: assert property (
		in_space <= 32'h10)
		else $error("input space above sixteen");
	chk_out_words_range: assert property (
		take && i_req.cmd == phc_pkg::CMD_MEM_RD && bar_hit[0] &&
		i_req.addr[16:0] == 17'h00020 && i_out_fifo_words <= 4'h8
		|=> rsp_reg.rdata == {28'h0, $past(i_out_fifo_words)})
		else $error("output words read wrong");
	chk_cmd_zero_block: assert property (
		take && command_reg == 3'h0 && i_req.cmd inside
		{phc_pkg::CMD_MEM_RD, phc_pkg::CMD_MEM_WR} |=> !rsp_reg.claimed)
		else $error("memory cycle claimed with command zero");
	chk_soft_rst_len: assert property (
		$rose(core_rst_reg) |-> core_rst_reg [*8])
		else $error("soft reset too short");
	chk_rom_strobe: assert property (
		!rom_stb_n_reg |-> rom_oe_reg)
		else $error("ROM strobe without address drive");
	chk_rom_answer: assert property (
		$fell(rom_stb_n_reg) |-> ##[3:15] rsp_reg.done)
		else $error("ROM read never answered");
	chk_revision: assert property (
		take && i_req.cmd == phc_pkg::CMD_CFG_RD &&
		i_req.addr[7:0] == 8'h08 |=> rsp_reg.rdata[7:0] == REVISION)
		else $error("revision code wrong");
	chk_beyond_header: assert property (
		take && i_req.cmd == phc_pkg::CMD_CFG_RD && i_req.addr[7:6] != 2'b00
		|=> rsp_reg.rdata == 32'h0)
		else $error("device-specific config bytes not zero");

	cov_rom_read: cover property ($fell(rom_stb_n_reg) ##[1:15] rsp_reg.done);
	cov_soft_reset: cover property ($fell(core_rst_reg));
	cov_int_raise: cover property ($fell(inta_n_reg));
	cov_swap_read: cover property (take && i_req.addr[16] && bar_hit[0]);

endmodule : phc_regs

// file: test/phc_rom_model.sv
// Boot ROM stand-in on the shared local memory data pins.
// Assumes one clock shared with the register block.
`timescale 1ns/1ps
module phc_rom_model (
	input  wire logic        i_clock,
	input  wire logic [15:0] i_rom_addr,
	input  wire logic        i_rom_addr_oe,
	input  wire logic        i_rom_read_strobe_n,
	output logic      [7:0]  o_rom_rdata
);
	logic [7:0] last_reg = 8'h00; // Last level on the data pins
	logic       sel;              // Address driven and strobe low
	assign sel = !i_rom_read_strobe_n && i_rom_addr_oe;
	// answer reads only
	// Released pins wander so stale data never passes as valid
	assign o_rom_rdata = sel ? (i_rom_addr[15:8] ^ i_rom_addr[7:0])
		: ~last_reg;
	// Remember the pins for the wander pattern
	always @(posedge i_clock) begin
		last_reg <= o_rom_rdata;
	end
endmodule : phc_rom_model

// file: test/tb_phc_regs.sv
// Self-checking bench for the configuration and control registers.
// Assumes the ROM stand-in on the shared pins and a 25 MHz clock.
`timescale 1ns/1ps
`include "phc_defines.svh"
module tb_phc_regs;
	localparam logic [7:0]  REV = 8'h3C;          // Arbitrary value
	localparam logic [31:0] CB  = 32'h1000_0000;  // Control base
	logic              i_clock = 1'b0;  // Bus clock
	logic              i_rst_n = 1'b0;  // Reset, held at start
	logic              en      = 1'b1;  // Clock enable
	phc_pkg::phc_req_s req     = '0;    // Request to the block
	phc_pkg::phc_rsp_s rsp;             // Answer from the block
	logic              bcz     = 1'b0;  // Class strap
	logic [1:0]        lat     = 2'h1;  // Max latency strap
	logic [4:0]        iev     = '0;    // Interrupt events
	logic [4:0]        sev     = '0;    // Status events
	logic [5:0]        in_used = '0;    // Input queue fill
	logic [3:0]        out_w   = '0;    // Output queue fill
	logic [15:0]       ra;              // ROM address pins
	logic              oe, stb_n, srst, inta_n;
	logic [7:0]        rd8;             // ROM data pins
	logic [31:0]       rdat;            // Last read data
	logic              claim, saw_stb;  // Last claim, strobe seen
	int                error_cnt = 0;
	int                checks_done = 0;

	always #20 i_clock = ~i_clock;

	phc_regs #(.REVISION(REV)) uut (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_clk_en(en), .i_req(req), .o_rsp(rsp),
		.i_base_class_zero(bcz), .i_max_lat_strap(lat), .i_int_events(iev),
		.i_status_events(sev), .i_in_fifo_used(in_used),
		.i_out_fifo_words(out_w), .o_rom_addr(ra), .o_rom_addr_oe(oe),
		.i_rom_rdata(rd8), .o_rom_read_strobe_n(stb_n),
		.o_core_soft_reset(srst), .o_inta_n(inta_n));

	phc_rom_model rom (.i_clock(i_clock), .i_rom_addr(ra),
		.i_rom_addr_oe(oe), .i_rom_read_strobe_n(stb_n), .o_rom_rdata(rd8));

	// Compare one value and count it
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// One transfer: pulse the request, then wait a bounded time
	task automatic acc(input phc_pkg::phc_cmd_e c, input logic [31:0] a,
		input logic [31:0] d, input logic [3:0] b);
		int n;
		@(negedge i_clock);
		req <= {1'b1, c, a, d, b};
		@(negedge i_clock);
		req.valid <= 1'b0;
		saw_stb = 1'b0;
		for (n = 0; n < 20 && rsp.done !== 1'b1; n++) begin
			@(negedge i_clock);
			if (stb_n === 1'b0) saw_stb = 1'b1;
		end
		rdat = rsp.rdata;
		claim = rsp.claimed;
		chk(32'(rsp.done), 32'h1, "no answer");
	endtask : acc

	task automatic cr(input logic [7:0] a);
		acc(phc_pkg::CMD_CFG_RD, 32'(a), 32'h0, 4'hF);
	endtask : cr
	task automatic cw(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] b);
		acc(phc_pkg::CMD_CFG_WR, 32'(a), d, b);
	endtask : cw
	task automatic mr(input logic [31:0] a);
		acc(phc_pkg::CMD_MEM_RD, a, 32'h0, 4'hF);
	endtask : mr
	task automatic mw(input logic [31:0] a, input logic [31:0] d);
		acc(phc_pkg::CMD_MEM_WR, a, d, 4'hF);
	endtask : mw

	// Print counts and verdict, then stop
	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	// Watchdog well past the expected run length
	initial begin
		#(40 * 4000);
		error_cnt++;
		complete_run();
	end

	// Main sequence
	initial begin
		repeat (4) @(negedge i_clock);
		i_rst_n = 1'b1;
		cr(`PHC_CFG_CLASSREV);
		chk(rdat, {`PHC_CLASS_DISPLAY, REV}, "class");
		cr(`PHC_CFG_MISC);
		chk(32'(rdat[23:16]), 32'h0, "hdr type");
		cw(`PHC_CFG_MISC, 32'h0000_AB00, 4'h2);
		cr(`PHC_CFG_MISC);
		chk(32'(rdat[15:8]), 32'hAB, "latency");
		cr(`PHC_CFG_INTR);
		chk(32'(rdat[31:24]), 32'h40, "max lat");
		cr(8'h40);
		chk(rdat, 32'h0, "unused cfg");
		$display("test ident done");
		cw(`PHC_CFG_BAR0, 32'hFFFF_FFFF, 4'hF);
		cr(`PHC_CFG_BAR0);
		chk(rdat, 32'hFFFE_0000, "bar0 size");
		for (int i = 0; i < 4; i++) begin
			cw(`PHC_CFG_BAR1 + 8'(4 * i), 32'hFFFF_FFFF, 4'hF);
			cr(`PHC_CFG_BAR1 + 8'(4 * i));
			chk(rdat, i[0] ? 32'hFE00_0000 : 32'hFF00_0000, "ap");
		end
		cw(`PHC_CFG_BAR0, CB, 4'hF);
		cw(`PHC_CFG_CMDSTAT, 32'h2, 4'h1);
		$display("test bars done");
		in_used = 6'd20;
		out_w = 4'd8;
		mr(CB + `PHC_R0_IN_SPACE);
		chk(rdat, 32'd12, "space");
		in_used = 6'd5;
		mr(CB + `PHC_R0_IN_SPACE);
		chk(rdat, 32'd16, "space cap");
		mr(CB + `PHC_R0_OUT_WORDS);
		chk(rdat, 32'd8, "out words");
		$display("test queues done");
		mr(CB + `PHC_R0_INT_EN);
		chk(rdat, 32'h0, "en reset");
		iev = 5'h04;
		@(negedge i_clock);
		iev = 5'h00;
		repeat (2) @(negedge i_clock);
		chk(32'(inta_n), 32'h1, "masked irq");
		mw(CB + `PHC_R0_INT_EN, 32'h1F);
		mr(CB + `PHC_R0_INT_EN);
		chk(rdat, 32'h1F, "enables");
		chk(32'(inta_n), 32'h0, "irq on");
		mw(CB + `PHC_R0_INT_FLAGS, 32'h0);
		mr(CB + `PHC_R0_INT_FLAGS);
		chk(rdat, 32'h4, "flag kept");
		mw(CB + `PHC_R0_INT_FLAGS, 32'h4);
		chk(32'(inta_n), 32'h1, "irq off");
		mr(CB + `PHC_R0_INT_FLAGS);
		chk(rdat, 32'h0, "flag clr");
		mr(CB + 32'h1_0008);
		chk(rdat, 32'h1F00_0000, "swapped");
		$display("test irq done");
		mw(CB + `PHC_R0_SOFT_RESET, 32'h0);
		chk(32'(srst), 32'h1, "soft rst");
		en = 1'b0;
		repeat (30) @(negedge i_clock);
		chk(32'(srst), 32'h1, "frozen");
		en = 1'b1;
		mr(CB + `PHC_R0_SOFT_RESET);
		chk(32'(rdat[31]), 32'h1, "busy");
		repeat (20) @(negedge i_clock);
		chk(32'(srst), 32'h0, "soft end");
		mr(CB + `PHC_R0_SOFT_RESET);
		chk(32'(rdat[31]), 32'h0, "idle");
		mr(CB + `PHC_R0_INT_EN);
		chk(rdat, 32'h1F, "kept");
		$display("test soft done");
		sev = 5'h01;
		@(negedge i_clock);
		sev = 5'h00;
		cr(`PHC_CFG_CMDSTAT);
		cr(`PHC_CFG_CMDSTAT);
		chk(32'(|rdat[31:27]), 32'h1, "stat set");
		cw(`PHC_CFG_CMDSTAT, 32'hF800_0002, 4'hF);
		cr(`PHC_CFG_CMDSTAT);
		chk(32'(rdat[31:27]), 32'h0, "stat clr");
		$display("test status done");
		cw(`PHC_CFG_ROMBAR, 32'h2000_0001, 4'hF);
		mr(32'h2000_1234);
		chk(rdat, 32'h2626_2626, "rom data");
		chk(32'(saw_stb), 32'h1, "rom strobe");
		mw(32'h2000_1234, 32'h5);
		chk(32'(claim), 32'h0, "rom write");
		cw(`PHC_CFG_CMDSTAT, 32'h0, 4'h1);
		mr(CB + `PHC_R0_IN_SPACE);
		chk(32'(claim), 32'h0, "cmd zero");
		cr(`PHC_CFG_CLASSREV);
		chk(32'(claim), 32'h1, "cfg still");
		$display("test rom done");
		i_rst_n = 1'b0;
		bcz = 1'b1;
		lat = 2'h3;
		repeat (8) @(negedge i_clock);
		i_rst_n = 1'b1;
		cr(`PHC_CFG_CLASSREV);
		chk(32'(rdat[31:8]), 32'h0, "compat");
		cr(`PHC_CFG_INTR);
		chk(32'(rdat[31:24]), 32'hC0, "max lat");
		$display("test straps done");
		complete_run();
	end
endmodule : tb_phc_regs
